// ---- hdl/osw_pkg.sv ----
// Constants, types and shared functions of the octal switch register bank.
package osw_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_SWITCH = 7'h01;
    localparam logic [6:0] ADDR_ERRCFG = 7'h02;
    localparam logic [6:0] ADDR_ERRFLG = 7'h03;
    localparam logic [6:0] ADDR_BURST  = 7'h05;
    localparam logic [6:0] ADDR_SWRST  = 7'h0B;

    localparam logic [7:0] RST_SWITCH  = 8'h00;
    localparam logic [7:0] RST_ERRCFG  = 8'h06;
    localparam logic [7:0] RST_ERRFLG  = 8'h00;
    localparam logic [7:0] RST_BURST   = 8'h00;
    localparam logic [7:0] MASK_ERRCFG = 8'h07;
    localparam logic [7:0] MASK_ERRFLG = 8'h07;
    localparam logic [7:0] MASK_BURST  = 8'h01;
    localparam logic [7:0] READ_ZERO   = 8'h00;

    // Bit positions in the error check enable, error indicator and burst enable registers.
    localparam int BIT_CRC  = 0;
    localparam int BIT_SCLK = 1;
    localparam int BIT_RW   = 2;
    localparam int BIT_BURST = 0;

    // ------------------------------------------------------------------
    // Frame layout and special commands
    // ------------------------------------------------------------------
    localparam logic [7:0]  KEY_FIRST   = 8'hA3;
    localparam logic [7:0]  KEY_SECOND  = 8'h05;
    localparam logic [15:0] CLEAR_FRAME = 16'h6CA9;
    localparam logic [7:0]  ALIGN_BYTE  = 8'h25;
    localparam logic [7:0]  CRC_POLY    = 8'h07;
    localparam logic [7:0]  CRC_SEED    = 8'h00;
    localparam logic [4:0]  WORD_SHORT  = 5'h10;
    localparam logic [4:0]  WORD_LONG   = 5'h18;
    localparam logic [4:0]  POS_ADDR    = 5'h07;
    localparam logic [4:0]  POS_ZERO    = 5'h00;
    localparam logic [4:0]  POS_ONE     = 5'h01;
    localparam logic [4:0]  TX_TOP      = 5'h17;
    localparam logic [2:0]  WORDS_ZERO  = 3'h0;
    localparam logic [2:0]  WORDS_ONE   = 3'h1;
    localparam logic [2:0]  WORDS_MAX   = 3'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int BBM_NS        = 300;
    localparam int BBM_CYC_INT   = (BBM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BBM_COUNT = 4'(BBM_CYC_INT < 1 ? 1 : BBM_CYC_INT);
    localparam logic [3:0] CNT_ONE   = 4'h1;
    localparam logic [3:0] CNT_ZERO  = 4'h0;

    typedef enum logic [0:0] {
        OSW_SW_STEADY = 1'b0,
        OSW_SW_BREAK  = 1'b1
    } osw_sw_state_t;

    // CRC-8, polynomial x^8+x^2+x+1, seed zero, data taken MSB first.
    function automatic logic [7:0] osw_crc8(input logic [15:0] data);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// ---- hdl/osw_link_if.sv ----
// Carrier between the serial link logic and the register core.
`timescale 1ns/100ps
interface osw_link_if;
    import osw_pkg::*;
    logic [23:0] word;
    logic        word_tgl;
    logic [4:0]  pos;
    logic [2:0]  words;
    logic [31:0] regs_snap;
    logic        crc_en;
    logic        burst_en;
    logic        link_rst;

    modport link (output word, word_tgl, pos, words,
                  input regs_snap, crc_en, burst_en, link_rst);
    modport core (input word, word_tgl, pos, words,
                  output regs_snap, crc_en, burst_en, link_rst);
endinterface

// ---- hdl/osw_spi_link.sv ----
// Serial link logic running on the serial clock.
`timescale 1ns/100ps
module osw_spi_link
    import osw_pkg::*;
(
    input  wire logic   sclk,    // Serial clock from the host.
    input  wire logic   cs_n,    // Chip select, active low.
    input  wire logic   sdi,     // Serial data in.
    output logic        sdo,     // Serial data out.
    output logic        sdo_oe,  // High while sdo is driven.
    osw_link_if.link    lk       // Words to and snapshot from the core.
);

    // ------------------------------------------------------------------
    // Receive side, rising edge
    // ------------------------------------------------------------------
    logic        first_reg;
    logic [23:0] shift_reg, shift_next;
    logic [4:0]  pos_reg, pos_next;
    logic [2:0]  words_reg, words_next;
    logic [6:0]  addr_reg, addr_next;
    logic [23:0] word_reg, word_next;
    logic        tgl_reg, tgl_next;
    logic [33:0] sync1_reg, sync2_reg;
    logic [4:0]  wlen;
    logic [4:0]  cnt;
    logic [4:0]  cnt_inc;
    logic [2:0]  wcur;
    logic        done;

    always_comb begin
        wlen       = sync2_reg[33] ? WORD_LONG : WORD_SHORT;
        cnt        = first_reg ? POS_ZERO : pos_reg;
        wcur       = first_reg ? WORDS_ZERO : words_reg;
        cnt_inc    = cnt + POS_ONE;
        done       = (cnt_inc == wlen);
        shift_next = {shift_reg[22:0], sdi};
        pos_next   = done ? POS_ZERO : cnt_inc;
        addr_next  = (cnt == POS_ADDR) ? shift_next[6:0] : addr_reg;
        words_next = (done && wcur != WORDS_MAX) ? wcur + 3'h1 : wcur;
        word_next  = word_reg;
        tgl_next   = tgl_reg;
        if (done && (sync2_reg[32] || wcur == WORDS_ZERO)) begin
            word_next = shift_next;
            tgl_next  = ~tgl_reg;
        end
    end

    // Chip select high re-arms the frame start; the shift, count and word registers are not cleared.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_ff @(posedge sclk) begin
        shift_reg <= shift_next;
        pos_reg   <= pos_next;
        words_reg <= words_next;
        addr_reg  <= addr_next;
        word_reg  <= word_next;
    end

    // The toggle must be known before the first frame, or the core sees a false word.
    // The serial clock is still during reset, so the release is safe.
    always_ff @(posedge sclk or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            tgl_reg <= 1'b0;
        end else begin
            tgl_reg <= tgl_next;
        end
    end

    // The snapshot is refilled by the first two edges of every frame.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sync1_reg <= 34'h0;
            sync2_reg <= 34'h0;
        end else begin
            sync1_reg <= {lk.crc_en, lk.burst_en, lk.regs_snap};
            sync2_reg <= sync1_reg;
        end
    end

    assign lk.word     = word_reg;
    assign lk.word_tgl = tgl_reg;
    assign lk.pos      = pos_reg;
    assign lk.words    = words_reg;

    // ------------------------------------------------------------------
    // Transmit side, falling edge
    // ------------------------------------------------------------------
    logic [7:0]  rdata;
    logic [23:0] tx;
    logic        sdo_next;

    always_comb begin
        case (addr_reg)
            ADDR_SWITCH: rdata = sync2_reg[7:0];
            ADDR_ERRCFG: rdata = sync2_reg[15:8];
            ADDR_ERRFLG: rdata = sync2_reg[23:16];
            ADDR_BURST:  rdata = sync2_reg[31:24];
            default:     rdata = READ_ZERO;
        endcase
        tx       = {ALIGN_BYTE, rdata, osw_crc8({ALIGN_BYTE, rdata})};
        sdo_next = tx[TX_TOP - pos_reg];
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo    <= sdo_next;
            sdo_oe <= 1'b1;
        end
    end

endmodule

// ---- hdl/osw_regs.sv ----
// Register bank and switch drive of the serially controlled octal switch.
`timescale 1ns/100ps

// Contract
// - Switch state register at 0x01, read and write, resets to 0x00.
// - Bit n of switch state closes switch n+1 when 1, opens it when 0.
// - Error check enables at 0x02, reset 0x06: address, clock count, CRC.
// - Read-only error flags at 0x03, reset 0x00: address, count, CRC.
// - Switches turning off open before any switch turning on closes.
// - Burst enable bit 0 allows back-to-back commands in one frame, aligned.
// - Writes 0xA3 then 0x05 to 0x0B return all registers to default.
// - Frame 0x6CA9 with good CRC clears all error flags, no address error.
// - Enabled address check flags writes to absent or read-only registers.
module osw_regs
    import osw_pkg::*;
(
    input  wire logic        clk,           // System clock, 10 MHz.
    input  wire logic        reset_n,       // Synchronous reset, active low.
    input  wire logic        sclk,          // Serial clock from the host.
    input  wire logic        cs_n,          // Chip select, active low.
    input  wire logic        sdi,           // Serial data in.
    output logic             sdo,           // Serial data out.
    output logic             sdo_oe,        // High while sdo is driven.
    output logic [7:0]       switch_close   // One bit per switch, high closes it.
);

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    osw_link_if lk_if ();

    osw_spi_link u_link (
        .sclk   (sclk),
        .cs_n   (cs_n),
        .sdi    (sdi),
        .sdo    (sdo),
        .sdo_oe (sdo_oe),
        .lk     (lk_if.link)
    );

    // ------------------------------------------------------------------
    // Crossing from the serial clock
    // ------------------------------------------------------------------
    logic [2:0] tgl_sync_reg, tgl_sync_next;
    logic [2:0] cs_sync_reg, cs_sync_next;
    logic       word_evt;
    logic       frame_end;

    always_comb begin
        tgl_sync_next = {tgl_sync_reg[1:0], lk_if.word_tgl};
        cs_sync_next  = {cs_sync_reg[1:0], cs_n};
        word_evt      = tgl_sync_reg[2] ^ tgl_sync_reg[1];
        frame_end     = cs_sync_reg[1] & ~cs_sync_reg[2];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tgl_sync_reg <= 3'h0;
            cs_sync_reg  <= 3'h7;
        end else begin
            tgl_sync_reg <= tgl_sync_next;
            cs_sync_reg  <= cs_sync_next;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic [7:0]  switch_state_reg, switch_state_next;
    logic [7:0]  errcfg_reg, errcfg_next;
    logic [7:0]  errflg_reg, errflg_next;
    logic [7:0]  burst_reg, burst_next;
    logic        key_armed_reg, key_armed_next;

    logic        crc_on;
    logic [15:0] payload;
    logic        crc_bad;
    logic        is_read;
    logic [6:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        is_clear;
    logic        addr_valid;
    logic        addr_bad;
    logic        do_write;
    logic        count_ok;

    function automatic logic addr_ok(input logic rd, input logic [6:0] a);
        logic ok;
        ok = 1'b0;
        case (a)
            ADDR_SWITCH: ok = 1'b1;
            ADDR_ERRCFG: ok = 1'b1;
            ADDR_BURST:  ok = 1'b1;
            ADDR_SWRST:  ok = 1'b1;
            ADDR_ERRFLG: ok = rd;
            default:     ok = 1'b0;
        endcase
        return ok;
    endfunction

    always_comb begin
        crc_on     = errcfg_reg[BIT_CRC];
        payload    = crc_on ? lk_if.word[23:8] : lk_if.word[15:0];
        crc_bad    = crc_on && (osw_crc8(payload) != lk_if.word[7:0]);
        is_read    = payload[15];
        cmd_addr   = payload[14:8];
        cmd_data   = payload[7:0];
        is_clear   = (payload == CLEAR_FRAME);
        addr_valid = addr_ok(is_read, cmd_addr);
        addr_bad   = !addr_valid && !is_clear && errcfg_reg[BIT_RW];
        do_write   = word_evt && !crc_bad && !is_read && addr_valid && !is_clear;
        if (burst_reg[BIT_BURST]) begin
            count_ok = (lk_if.pos == POS_ZERO) && (lk_if.words != WORDS_ZERO);
        end else begin
            count_ok = (lk_if.pos == POS_ZERO) && (lk_if.words == WORDS_ONE);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_comb begin
        switch_state_next = switch_state_reg;
        errcfg_next       = errcfg_reg;
        errflg_next       = errflg_reg;
        burst_next        = burst_reg;
        key_armed_next    = key_armed_reg;

        // Clear first so that a flag raised by the same event survives.
        if (word_evt && !crc_bad && is_clear) begin
            errflg_next = RST_ERRFLG;
        end

        if (do_write) begin
            case (cmd_addr)
                ADDR_SWITCH: switch_state_next = cmd_data;
                ADDR_ERRCFG: errcfg_next = cmd_data & MASK_ERRCFG;
                ADDR_BURST:  burst_next = cmd_data & MASK_BURST;
                default:     switch_state_next = switch_state_reg;
            endcase
        end

        if (word_evt && !crc_bad) begin
            key_armed_next = do_write && (cmd_addr == ADDR_SWRST)
                             && (cmd_data == KEY_FIRST);
        end

        if (word_evt && crc_bad) begin
            errflg_next[BIT_CRC] = 1'b1;
        end
        if (word_evt && !crc_bad && addr_bad) begin
            errflg_next[BIT_RW] = 1'b1;
        end
        if (frame_end && errcfg_reg[BIT_SCLK] && !count_ok) begin
            errflg_next[BIT_SCLK] = 1'b1;
        end

        if (do_write && key_armed_reg && (cmd_addr == ADDR_SWRST)
                && (cmd_data == KEY_SECOND)) begin
            switch_state_next = RST_SWITCH;
            errcfg_next       = RST_ERRCFG;
            errflg_next       = RST_ERRFLG;
            burst_next        = RST_BURST;
            key_armed_next    = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            switch_state_reg <= RST_SWITCH;
            errcfg_reg       <= RST_ERRCFG;
            errflg_reg       <= RST_ERRFLG;
            burst_reg        <= RST_BURST;
            key_armed_reg    <= 1'b0;
        end else begin
            switch_state_reg <= switch_state_next;
            errcfg_reg       <= errcfg_next;
            errflg_reg       <= errflg_next & MASK_ERRFLG;
            burst_reg        <= burst_next;
            key_armed_reg    <= key_armed_next;
        end
    end

    assign lk_if.regs_snap = {burst_reg, errflg_reg, errcfg_reg, switch_state_reg};
    assign lk_if.crc_en    = errcfg_reg[BIT_CRC];
    assign lk_if.burst_en  = burst_reg[BIT_BURST];
    assign lk_if.link_rst  = ~reset_n;

    // ------------------------------------------------------------------
    // Switch drive with break-before-make
    // ------------------------------------------------------------------
    osw_sw_state_t sw_state_reg, sw_state_next;
    logic [7:0]    switch_next;
    logic [3:0]    bbm_cnt_reg, bbm_cnt_next;
    logic [7:0]    opening;
    logic [7:0]    closing;

    always_comb begin
        sw_state_next = sw_state_reg;
        switch_next   = switch_close;
        bbm_cnt_next  = bbm_cnt_reg;
        opening       = switch_close & ~switch_state_reg;
        closing       = switch_state_reg & ~switch_close;
        case (sw_state_reg)
            OSW_SW_STEADY: begin
                if (opening != READ_ZERO && closing != READ_ZERO) begin
                    switch_next   = switch_close & switch_state_reg;
                    bbm_cnt_next  = BBM_COUNT;
                    sw_state_next = OSW_SW_BREAK;
                end else begin
                    switch_next = switch_state_reg;
                end
            end
            OSW_SW_BREAK: begin
                if (bbm_cnt_reg == CNT_ONE) begin
                    switch_next   = switch_close & switch_state_reg;
                    bbm_cnt_next  = CNT_ZERO;
                    sw_state_next = OSW_SW_STEADY;
                end else begin
                    bbm_cnt_next = bbm_cnt_reg - CNT_ONE;
                end
            end
            default: begin
                switch_next   = RST_SWITCH;
                bbm_cnt_next  = CNT_ZERO;
                sw_state_next = OSW_SW_STEADY;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_state_reg <= OSW_SW_STEADY;
            switch_close <= RST_SWITCH;
            bbm_cnt_reg  <= CNT_ZERO;
        end else begin
            sw_state_reg <= sw_state_next;
            switch_close <= switch_next;
            bbm_cnt_reg  <= bbm_cnt_next;
        end
    end

endmodule

// ---- test/osw_regs_asserts.sv ----
// Port checker for the octal switch register bank.
`timescale 1ns/100ps
module osw_regs_asserts
    import osw_pkg::*;
(
    input  wire logic       clk,          // System clock.
    input  wire logic       reset_n,      // Synchronous reset, active low.
    input  wire logic       sclk,         // Serial clock.
    input  wire logic       cs_n,         // Chip select, active low.
    input  wire logic       sdi,          // Serial data in.
    input  wire logic       sdo,          // Serial data out.
    input  wire logic       sdo_oe,       // Serial output enable.
    input  wire logic [7:0] switch_close  // Switch drive.
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [4:0] edge_cnt;
    logic [3:0] idle_cnt;
    logic [7:0] prev_sw;
    logic [7:0] opened;
    logic [7:0] closed;

    assign opened = prev_sw & ~switch_close;
    assign closed = ~prev_sw & switch_close;

    // Counts serial rising edges in a frame, saturating.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) edge_cnt <= 5'h00;
        else if (edge_cnt != 5'h1F) edge_cnt <= edge_cnt + 5'h01;
    end

    always_ff @(posedge clk) begin
        prev_sw <= switch_close;
        if (!reset_n || !cs_n) idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_reset_open: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_n) |-> switch_close == 8'h00) else $error("switches closed after reset");
    chk_no_overlap: assert property (@(posedge clk) disable iff (!reset_n)
        (|closed) |-> !(|opened)) else $error("switch opened and closed together");
    chk_break_first: assert property (@(posedge clk) disable iff (!reset_n)
        (|opened) |=> !(|closed) [*2]) else $error("closing too soon after opening");
    chk_idle_steady: assert property (@(posedge clk) disable iff (!reset_n)
        idle_cnt == 4'hF |-> $stable(switch_close)) else $error("switches moved with no frame");
    chk_quiet_oe: assert property (@(posedge clk) disable iff (!reset_n)
        cs_n |-> !sdo_oe) else $error("sdo enabled outside frame");
    chk_quiet_sdo: assert property (@(posedge clk) disable iff (!reset_n)
        cs_n |-> !sdo) else $error("sdo high outside frame");
    chk_align_bits: assert property (@(posedge sclk) disable iff (cs_n)
        edge_cnt inside {[1:7]} |-> sdo == ALIGN_BYTE[5'd7 - edge_cnt])
        else $error("alignment bit wrong");
    chk_oe_frame: assert property (@(posedge sclk) disable iff (cs_n)
        edge_cnt != 5'h00 |-> sdo_oe) else $error("sdo not driven in frame");

    cov_mixed: cover property (@(posedge clk) (|opened) ##[1:6] (|closed));
    cov_long: cover property (@(posedge sclk) edge_cnt == 5'h1F);
    cov_top: cover property (@(posedge clk) switch_close == 8'h80);
endmodule

bind osw_regs osw_regs_asserts chk_u (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .switch_close(switch_close));

// ---- test/osw_spi_host.sv ----
// Behavioural serial host that drives frames into the switch register bank.
`timescale 1ns/100ps
module osw_spi_host (
    output logic sclk,    // Serial clock, low and still between frames.
    output logic cs_n,    // Chip select, active low.
    output logic sdi,     // Serial data to the device.
    input  wire logic sdo,    // Serial data from the device.
    input  wire logic sdo_oe  // Device drives sdo while high.
);
    logic line;

    // The output line has a pull-up when the device releases it.
    assign line = sdo_oe ? sdo : 1'b1;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    task automatic start();
        cs_n = 1'b0;
        #40;
    endtask

    // Leaves a long idle gap so the core has settled before the next frame.
    task automatic stop();
        #40;
        cs_n = 1'b1;
        sdi = ~sdi;
        #1200;
    endtask

    // Sends one word, with a CRC byte when enabled; bad flips bit 0 of the CRC.
    task automatic xfer(input logic [15:0] w, input logic crc_on, input logic bad,
                        output logic [7:0] data);
        logic [23:0] bits;
        logic [15:0] rx;
        bits = {w, crc8(w) ^ {7'h00, bad}};
        rx = 16'h0000;
        for (int i = 23; i >= (crc_on ? 0 : 8); i--) begin
            sdi = bits[i];
            #3 sclk = 1'b1;
            if (i >= 8) rx = {rx[14:0], line};
            #3 sclk = 1'b0;
        end
        data = rx[7:0];
    endtask
endmodule

// ---- test/octal_switch_control_registers_tb_top.sv ----
// Self-checking testbench of the octal switch register bank.
`timescale 1ns/100ps
module octal_switch_control_registers_tb_top
    import osw_pkg::*;
;
    logic       clk;
    logic       reset_n;
    logic       sclk;
    logic       cs_n;
    logic       sdi;
    logic       sdo;
    logic       sdo_oe;
    logic [7:0] switch_close;
    logic [7:0] rx;
    logic       crc_on;
    int         err_count;
    int         n_checks;

    osw_regs dut_u (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .switch_close(switch_close));
    osw_spi_host host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_sw(input logic [7:0] exp);
        @(negedge clk);
        chk8(switch_close, exp);
    endtask

    task automatic send(input logic [15:0] w, input logic bad);
        host_u.start();
        host_u.xfer(w, crc_on, bad, rx);
        host_u.stop();
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        send({1'b0, a, d}, 1'b0);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        send({1'b1, a, 8'h00}, 1'b0);
        chk8(rx, exp);
    endtask

    // Two words in one frame; rx keeps the second word's data byte.
    task automatic pair(input logic [15:0] w0, input logic [15:0] w1);
        host_u.start();
        host_u.xfer(w0, crc_on, 1'b0, rx);
        #600;
        host_u.xfer(w1, crc_on, 1'b0, rx);
        host_u.stop();
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        reset_n = 1'b0;
        crc_on = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        chk_sw(8'h00);
        rd(ADDR_SWITCH, 8'h00);
        rd(ADDR_ERRCFG, 8'h06);
        rd(ADDR_ERRFLG, 8'h00);
        rd(ADDR_BURST, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SWITCH, 8'h01 << i);
            chk_sw(8'h01 << i);
        end
        rd(ADDR_SWITCH, 8'h80);
        wr(ADDR_ERRCFG, 8'hFE);
        rd(ADDR_ERRCFG, 8'h06);
        wr(ADDR_BURST, 8'hFE);
        rd(ADDR_BURST, 8'h00);
        wr(ADDR_ERRFLG, 8'hFF);
        wr(7'h7F, 8'hFF);
        rd(ADDR_ERRFLG, 8'h04);
        chk_sw(8'h80);
        send(CLEAR_FRAME, 1'b0);
        rd(ADDR_ERRFLG, 8'h00);
        pair({1'b0, ADDR_SWITCH, 8'h0F}, {1'b0, ADDR_SWITCH, 8'hF0});
        chk_sw(8'h0F);
        rd(ADDR_ERRFLG, 8'h02);
        send(CLEAR_FRAME, 1'b0);
        wr(ADDR_BURST, 8'h01);
        pair({1'b0, ADDR_SWITCH, 8'h3C}, {1'b1, ADDR_SWITCH, 8'h00});
        chk8(rx, 8'h3C);
        chk_sw(8'h3C);
        rd(ADDR_ERRFLG, 8'h00);
        wr(ADDR_ERRCFG, 8'h07);
        crc_on = 1'b1;
        send({1'b0, ADDR_SWITCH, 8'hAA}, 1'b1);
        chk_sw(8'h3C);
        rd(ADDR_ERRFLG, 8'h01);
        send(CLEAR_FRAME, 1'b1);
        rd(ADDR_ERRFLG, 8'h01);
        send(CLEAR_FRAME, 1'b0);
        rd(ADDR_ERRFLG, 8'h00);
        wr(ADDR_SWITCH, 8'h55);
        chk_sw(8'h55);
        wr(ADDR_SWRST, KEY_FIRST);
        wr(ADDR_SWRST, KEY_SECOND);
        crc_on = 1'b0;
        chk_sw(8'h00);
        rd(ADDR_ERRCFG, 8'h06);
        rd(ADDR_BURST, 8'h00);
        finish_test();
    end
endmodule
